// File: hdl/nps_pkg.sv
// Purpose: shared constants and types of the nanoprogram sequencer
// Assumes: 10 MHz system clock, one sys clock per AHB-Lite bus cycle
// Notes:   nanoword = 4 T-step command slices plus K-vector fields
package nps_pkg;
   // clock and T-step timing
   localparam int CLK_MHZ   = 10;
   localparam int TSTEP_NS  = 400;
   localparam int TSTEP_CYC = (TSTEP_NS * CLK_MHZ + 999) / 1000;
   localparam int TCYC_W    = 2;
   localparam logic [TCYC_W-1:0] TCYC_LAST = TCYC_W'(TSTEP_CYC - 1);
   localparam logic [1:0] T_FIRST = 2'h0;
   localparam logic [1:0] T_LAST  = 2'h3;

   // widths
   localparam int NSA_W = 10;
   localparam int CSW   = 18;
   localparam int PG_W  = 4;
   localparam int OP_W  = 6;
   localparam int NCMD  = 9;
   localparam int NW_W  = 56;

   // command bits inside one T-step slice
   localparam int CMD_NS_RD    = 0;
   localparam int CMD_NS_RD_BR = 1;
   localparam int CMD_NS_GATE  = 2;
   localparam int CMD_CS_RD_P1 = 3;
   localparam int CMD_CS_RD_P2 = 4;
   localparam int CMD_NPA_LD   = 5;
   localparam int CMD_UPC_INC  = 6;
   localparam int CMD_PARAM_LD = 7;
   localparam int CMD_SH_GATE  = 8;

   // K-vector fields of a nanoword
   localparam int NW_LEGAL  = 36;
   localparam int NW_ALLOW  = 37;
   localparam int NW_BR_LO  = 38;
   localparam int NW_SHA_LO = 48;
   localparam int SHA_W     = 6;
   localparam int NW_SHC_LO = 54;
   localparam int SHC_W     = 2;

   // microinstruction word: opcode, A, B
   localparam int MI_AB_W = 12;

   // register offsets (byte addresses)
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_START  = 8'h04;
   localparam logic [7:0] REG_SEL    = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_PARAM  = 8'h10;
   localparam logic [7:0] REG_CSBUS  = 8'h14;
   localparam logic [7:0] REG_UPC0   = 8'h20;
   localparam int CTRL_RUN   = 0;
   localparam int CTRL_START = 1;
   localparam int SEL_PG_LO  = 4;

   // reset values
   localparam logic [NSA_W-1:0] RST_START = 10'h000;
   localparam logic [CSW-1:0]   RST_UPC   = 18'h00000;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_ISEL} nps_state_e;
   typedef logic [NW_W-1:0] nps_nw_t;
endpackage : nps_pkg

// File: hdl/nps_step_if.sv
// Purpose: T-step timing carrier between sequencer and step timer
// Assumes: one clock domain
// Notes:   lead/trail are single-cycle strobes inside the active step
interface nps_step_if;
   logic [1:0] t_idx;
   logic       lead;
   logic       trail;
   logic       run;
   logic       restart;
   modport timer (input run, restart, output t_idx, lead, trail);
   modport ctrl  (output run, restart, input t_idx, lead, trail);
endinterface : nps_step_if

// File: hdl/nps_tstep.sv
// Purpose: divides the clock into T-steps T1..T4 of TSTEP_CYC cycles
// Assumes: synchronised active-low reset already released cleanly
// Notes:   restart at a trailing edge makes the next step T1
module nps_tstep
   import nps_pkg::*;
(
   input  wire logic  clk_in,   // system clock
   input  wire logic  rst_n_in, // synchronised reset, active low
   nps_step_if.timer  st        // step strobes
);
   logic [TCYC_W-1:0] cyc_q;
   logic [1:0]        idx_q;

   assign st.t_idx = idx_q;
   assign st.lead  = st.run && (cyc_q == '0);
   assign st.trail = st.run && (cyc_q == TCYC_LAST);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cyc_q <= '0;
         idx_q <= T_FIRST;
      end else if (!st.run) begin
         cyc_q <= '0;
         idx_q <= T_FIRST;
      end else if (st.trail) begin
         cyc_q <= '0;
         // a step with no command simply runs out here
         idx_q <= st.restart ? T_FIRST : idx_q + 2'h1;
      end else begin
         cyc_q <= cyc_q + TCYC_W'(1);
      end
   end
endmodule : nps_tstep

// File: hdl/nps_sequencer.sv
// Purpose: nanoprogram sequencer with AHB-Lite register access
// Assumes: memories answer one cycle after a read strobe
// Notes:   T-step = TSTEP_CYC clocks; reads, NPA load, shifter gate act at the step's lead; gate, UPC increment, param load at its trail
//
// Our own choices: the register offsets and the AHB-Lite slave port.
module nps_sequencer
   import nps_pkg::*;
(
   input  wire logic                sys_clk_in,       // 10 MHz clock
   input  wire logic                reset_n_in,       // async reset, low
   input  wire logic                hsel_in,          // AHB select
   input  wire logic [31:0]         haddr_in,         // AHB address
   input  wire logic [1:0]          htrans_in,        // AHB transfer type
   input  wire logic                hwrite_in,        // AHB write
   input  wire logic [2:0]          hsize_in,         // AHB size (word)
   input  wire logic [31:0]         hwdata_in,        // AHB write data
   input  wire logic                hready_in,        // AHB ready
   output      logic [31:0]         hrdata_out,       // AHB read data
   output      logic                hreadyout_out,    // AHB ready out
   output      logic                hresp_out,        // AHB response
   input  wire nps_pkg::nps_nw_t    ns_data_in,       // nanostore data
   output      logic [NSA_W-1:0]    ns_addr_out,      // nanostore addr
   output      logic                ns_rd_out,        // nanostore read
   input  wire logic [CSW-1:0]      cs_data_in,       // control store data
   output      logic [CSW-1:0]      cs_addr_out,      // control store addr
   output      logic                cs_rd_out,        // control store read
   input  wire logic                irq_in,           // interrupt request
   input  wire logic [NSA_W-1:0]    irq_addr_in,      // interrupt vector
   output      logic                irq_ack_out,      // interrupt accepted
   output      nps_pkg::nps_nw_t    nw_out,           // executing nanoword
   output      logic                nw_valid_out,     // nanoword executing
   output      logic [1:0]          tstep_out,        // current T-step
   output      logic                legal_entry_out,  // legal entry bit
   output      logic                int_allow_out,    // interrupt allow
   output      logic                shifter_gate_out, // shifter gate pulse
   output      logic [SHA_W-1:0]    shift_amount_out, // shift amount
   output      logic [SHC_W-1:0]    shift_ctrl_out,   // shift control
   output      logic [CSW-1:0]      param_reg_out,    // register 31
   output      logic [CSW-1:0]      cs_bus_out        // control store bus
);
   import nps_pkg::*;

   logic rst_s1_q, rst_n_q;
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   nps_step_if st_if();
   nps_tstep u_tstep (
      .clk_in   (sys_clk_in),
      .rst_n_in (rst_n_q),
      .st       (st_if.timer)
   );

   nps_state_e          state_q;
   nps_nw_t             cur_nw_q, ns_buf_q;
   logic [NSA_W-1:0]    npa_q, isel_q, start_addr_q;
   logic [CSW-1:0]      upc_q [4];
   logic [CSW-1:0]      cs_bus_q, param_q, cs_addr_q;
   logic [1:0]          csel_q;
   logic [PG_W-1:0]     page_q;
   logic                run_en_q, start_q, halted_q, allow_q, ack_q;
   logic                ns_rd_q, ns_pend_q, cs_rd_q, cs_pend_q, shg_q;
   logic [NSA_W-1:0]    ns_addr_q;
   logic [SHA_W-1:0]    sha_q;
   logic [SHC_W-1:0]    shc_q;
   logic [NCMD-1:0]     cmd;
   logic                exec, lead, trail, word_end, take_irq, ns_ok;

   assign lead  = st_if.lead;
   assign trail = st_if.trail;
   assign exec  = (state_q == ST_EXEC);
   assign cmd   = cur_nw_q[st_if.t_idx * NCMD +: NCMD];
   // a word ends at its gate step or, without a gate, after T4
   assign word_end = exec && trail &&
                     (cmd[CMD_NS_GATE] || st_if.t_idx == T_LAST);
   assign take_irq = word_end && allow_q && irq_in;
   assign st_if.run     = (state_q != ST_IDLE);
   assign st_if.restart = word_end || (state_q == ST_ISEL);
   // an allowing word may only take a nanobranch address at T1
   assign ns_ok = cmd[CMD_NS_RD_BR] || (cmd[CMD_NS_RD] &&
                  !(st_if.t_idx == T_FIRST && cur_nw_q[NW_ALLOW]));

   // ---- sequencing state ----
   always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q  <= ST_IDLE;
         isel_q   <= RST_START;
         halted_q <= 1'b0;
         ack_q    <= 1'b0;
      end else begin
         ack_q <= 1'b0;
         if (!run_en_q) begin
            state_q <= ST_IDLE;
         end else begin
            unique case (state_q)
               ST_IDLE: if (start_q) begin
                  state_q  <= ST_ISEL;
                  isel_q   <= start_addr_q;
                  halted_q <= 1'b0;
               end
               ST_EXEC: if (word_end) begin
                  if (take_irq) begin
                     // suspend; vector word replaces the gated one
                     state_q <= ST_ISEL;
                     isel_q  <= irq_addr_in;
                     ack_q   <= 1'b1;
                  end else if (!cmd[CMD_NS_GATE]) begin
                     state_q  <= ST_IDLE;
                     halted_q <= 1'b1;
                  end
               end
               ST_ISEL: if (trail) begin
                  state_q <= ST_EXEC;
               end
            endcase
         end
      end
   end

   // ---- executing nanoword and interrupt allow recognition ----
   always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cur_nw_q <= '0;
         allow_q  <= 1'b0;
      end else begin
         if (state_q == ST_ISEL && trail) begin
            cur_nw_q <= ns_data_in;
         end else if (exec && trail && cmd[CMD_NS_GATE]) begin
            // takes effect from the next T-step on
            cur_nw_q <= ns_buf_q;
         end
         if (word_end || state_q != ST_EXEC) begin
            allow_q <= 1'b0;
         end else if (lead && st_if.t_idx == T_FIRST) begin
            allow_q <= cur_nw_q[NW_ALLOW];
         end
      end
   end

   // ---- nanoprogram counter ----
   always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         npa_q <= RST_START;
      end else if (state_q == ST_ISEL && trail) begin
         npa_q <= isel_q;
      end else if (exec && lead && cmd[CMD_NPA_LD]) begin
         npa_q <= {page_q, cs_bus_q[CSW-1 -: OP_W]};
      end
   end

   // ---- nanostore port, independent of control store ----
   always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ns_rd_q   <= 1'b0;
         ns_pend_q <= 1'b0;
         ns_addr_q <= RST_START;
         ns_buf_q  <= '0;
      end else begin
         ns_rd_q <= 1'b0;
         if (state_q == ST_ISEL && lead) begin
            ns_rd_q   <= 1'b1;
            ns_addr_q <= isel_q;
         end else if (exec && lead && ns_ok) begin
            ns_rd_q   <= 1'b1;
            ns_pend_q <= 1'b1;
            ns_addr_q <= cmd[CMD_NS_RD_BR] ?
                         cur_nw_q[NW_BR_LO +: NSA_W] : npa_q;
         end else if (trail && ns_pend_q) begin
            ns_pend_q <= 1'b0;
            ns_buf_q  <= ns_data_in;
         end
      end
   end

   // ---- control store port ----
   always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cs_rd_q   <= 1'b0;
         cs_pend_q <= 1'b0;
         cs_addr_q <= RST_UPC;
         cs_bus_q  <= '0;
      end else begin
         cs_rd_q <= 1'b0;
         if (exec && lead && (cmd[CMD_CS_RD_P1] || cmd[CMD_CS_RD_P2])) begin
            cs_rd_q   <= 1'b1;
            cs_pend_q <= 1'b1;
            // address uses the counter before any same-step increment
            cs_addr_q <= upc_q[csel_q] +
                         (cmd[CMD_CS_RD_P1] ? 18'h1 : 18'h2);
         end else if (trail && cs_pend_q) begin
            cs_pend_q <= 1'b0;
            cs_bus_q  <= cs_data_in;
         end
      end
   end

   // ---- register 31 parameter load ----
   always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         param_q <= '0;
      end else if (exec && trail && cmd[CMD_PARAM_LD]) begin
         param_q <= {{(CSW-MI_AB_W){1'b0}},
                     cs_bus_q[MI_AB_W-1:0]};
      end
   end

   // ---- shifter timing; select setup is the program's own job ----
   always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         shg_q <= 1'b0;
         sha_q <= '0;
         shc_q <= '0;
      end else begin
         shg_q <= exec && lead && cmd[CMD_SH_GATE];
         // unset fields are zero in the word, so data passes straight
         sha_q <= exec ? cur_nw_q[NW_SHA_LO +: SHA_W] : '0;
         shc_q <= exec ? cur_nw_q[NW_SHC_LO +: SHC_W] : '0;
      end
   end

   // ---- AHB-Lite slave, zero wait states ----
   logic        ap, wr_pend_q;
   logic [7:0]  waddr_q;
   logic [31:0] rdata_q, rd_d;
   assign ap = hsel_in && hready_in && htrans_in[1];

   always_comb begin
      unique case (haddr_in[7:0])
         REG_CTRL:   rd_d = {31'h0, run_en_q};
         REG_START:  rd_d = {22'h0, start_addr_q};
         REG_SEL:    rd_d = {24'h0, page_q, 2'h0, csel_q};
         REG_STATUS: rd_d = {16'h0, allow_q, halted_q, npa_q,
                             st_if.t_idx, 2'(state_q)};
         REG_PARAM:  rd_d = {14'h0, param_q};
         REG_CSBUS:  rd_d = {14'h0, cs_bus_q};
         default:    rd_d = (haddr_in[7:4] == REG_UPC0[7:4]) ?
                            {14'h0, upc_q[haddr_in[3:2]]} : 32'h0;
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         wr_pend_q <= 1'b0;
         waddr_q   <= 8'h00;
         rdata_q   <= 32'h0;
      end else begin
         wr_pend_q <= ap && hwrite_in;
         if (ap) begin
            waddr_q <= haddr_in[7:0];
         end
         if (ap && !hwrite_in) begin
            rdata_q <= rd_d;
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         run_en_q     <= 1'b0;
         start_q      <= 1'b0;
         start_addr_q <= RST_START;
         csel_q       <= 2'h0;
         page_q       <= '0;
      end else begin
         start_q <= 1'b0;
         if (wr_pend_q) begin
            unique case (waddr_q)
               REG_CTRL: begin
                  run_en_q <= hwdata_in[CTRL_RUN];
                  start_q  <= hwdata_in[CTRL_START];
               end
               REG_START: start_addr_q <= hwdata_in[NSA_W-1:0];
               REG_SEL: begin
                  csel_q <= hwdata_in[1:0];
                  page_q <= hwdata_in[SEL_PG_LO +: PG_W];
               end
               default: ;
            endcase
         end
      end
   end

   // four micro counters; the select field picks the live one
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_upc
         always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
            if (!rst_n_q) begin
               upc_q[g] <= RST_UPC;
            end else if (wr_pend_q &&
                         waddr_q == REG_UPC0 + 8'(4 * g)) begin
               upc_q[g] <= hwdata_in[CSW-1:0];
            end else if (exec && trail && cmd[CMD_UPC_INC] &&
                         csel_q == 2'(g)) begin
               // done at trail so it is current before the next word
               upc_q[g] <= upc_q[g] + 18'h1;
            end
         end
      end
   endgenerate

   assign hrdata_out       = rdata_q;
   assign hreadyout_out    = 1'b1;
   assign hresp_out        = 1'b0;
   assign ns_addr_out      = ns_addr_q;
   assign ns_rd_out        = ns_rd_q;
   assign cs_addr_out      = cs_addr_q;
   assign cs_rd_out        = cs_rd_q;
   assign irq_ack_out      = ack_q;
   assign nw_out           = cur_nw_q;
   assign nw_valid_out     = exec;
   assign tstep_out        = st_if.t_idx;
   assign legal_entry_out  = exec && cur_nw_q[NW_LEGAL];
   assign int_allow_out    = allow_q;
   assign shifter_gate_out = shg_q;
   assign shift_amount_out = sha_q;
   assign shift_ctrl_out   = shc_q;
   assign param_reg_out    = param_q;
   assign cs_bus_out       = cs_bus_q;
endmodule : nps_sequencer

// File: tb/nps_mem_model.sv
// Purpose: behavioural control store and nanostore beside the sequencer
// Assumes: read data is wanted from the cycle after the strobe
// Notes:   stale data is inverted so a late capture cannot pass by luck
module nps_mem_model
   import nps_pkg::*;
(
   input  wire logic             clk_in,      // system clock
   input  wire logic [NSA_W-1:0] ns_addr_in,  // nanostore address
   input  wire logic             ns_rd_in,    // nanostore read
   output      nps_pkg::nps_nw_t ns_data_out, // nanostore word
   input  wire logic [CSW-1:0]   cs_addr_in,  // control store address
   input  wire logic             cs_rd_in,    // control store read
   output      logic [CSW-1:0]   cs_data_out  // control store word
);
   timeunit 1ns;
   timeprecision 1ns;
   nps_nw_t        ns [1024] = '{default: '0};
   logic [CSW-1:0] cs [1024] = '{default: '0};
   nps_nw_t        ns_q = '0;
   logic [CSW-1:0] cs_q = '0;
   logic [1:0]     ns_age = 2'h3;
   logic [1:0]     cs_age = 2'h3;
   // two private ports: a same-step access of both never collides
   always @(posedge clk_in) begin
      if (ns_rd_in) begin
         ns_q   <= ns[ns_addr_in];
         ns_age <= 2'h0;
      end else if (ns_age != 2'h3) begin
         ns_age <= ns_age + 2'h1;
      end
      if (cs_rd_in) begin
         cs_q   <= cs[cs_addr_in[9:0]];
         cs_age <= 2'h0;
      end else if (cs_age != 2'h3) begin
         cs_age <= cs_age + 2'h1;
      end
   end
   assign ns_data_out = (ns_age < 2'h2) ? ns_q : ~ns_q;
   assign cs_data_out = (cs_age < 2'h2) ? cs_q : ~cs_q;
endmodule : nps_mem_model

// File: tb/nps_sequencer_asserts.sv
// Purpose: port-level temporal checks of the nanoprogram sequencer
// Assumes: one clock domain, raw async reset used as disable
// Notes:   legal and shift fields are compared only once the word has settled
module nps_sequencer_asserts
   import nps_pkg::*;
(
   input wire logic             sys_clk_in,       // clock
   input wire logic             reset_n_in,       // reset, low
   input wire logic [NSA_W-1:0] irq_addr_in,      // vector
   input wire logic [NSA_W-1:0] ns_addr_out,      // ns address
   input wire logic             ns_rd_out,        // ns read
   input wire logic             cs_rd_out,        // cs read
   input wire logic             irq_ack_out,      // accept pulse
   input wire nps_pkg::nps_nw_t nw_out,           // executing word
   input wire logic             nw_valid_out,     // executing
   input wire logic [1:0]       tstep_out,        // T-step
   input wire logic             legal_entry_out,  // legal bit
   input wire logic             int_allow_out,    // allow seen
   input wire logic             shifter_gate_out, // shifter gate
   input wire logic [SHA_W-1:0] shift_amount_out, // shift amount
   input wire logic [SHC_W-1:0] shift_ctrl_out,   // shift control
   input wire logic [CSW-1:0]   param_reg_out,    // register 31
   input wire logic [CSW-1:0]   cs_bus_out        // cs word held
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);
   sequence s_vec_read;
      ##[1:5] (ns_rd_out && ns_addr_out == irq_addr_in);
   endsequence
   // the word outputs may lag the load by a cycle
   sequence s_settled;
      nw_valid_out && $past(nw_valid_out) && $stable(nw_out);
   endsequence
   AST_ACK_ALLOW: assert property (irq_ack_out
      |-> $past(int_allow_out))
      else $error("interrupt taken without allow");
   AST_ACK_VEC: assert property (irq_ack_out |-> s_vec_read)
      else $error("vector word not read after accept");
   AST_ISEL_GAP: assert property (irq_ack_out |=> !nw_valid_out [*3])
      else $error("vector select shorter than a step");
   AST_BR_T1: assert property (ns_rd_out && nw_valid_out
      && tstep_out == T_FIRST && nw_out[NW_ALLOW]
      |-> ns_addr_out == nw_out[NW_BR_LO +: NSA_W])
      else $error("first-step read in allowing word");
   AST_ALLOW_T1: assert property ($rose(int_allow_out) |-> nw_valid_out
      && tstep_out == T_FIRST && nw_out[NW_ALLOW])
      else $error("allow recognised outside first step");
   AST_STEP_LEN: assert property (nw_valid_out && $changed(tstep_out)
      |=> $stable(tstep_out) [*3])
      else $error("step shorter than four cycles");
   AST_SH_GATE: assert property (shifter_gate_out
      |-> nw_valid_out && nw_out[9 * tstep_out + 8])
      else $error("shifter gate without command");
   AST_LEGAL: assert property (s_settled
      |-> legal_entry_out == nw_out[NW_LEGAL])
      else $error("legal entry differs from word");
   AST_SHIFT: assert property (s_settled
      |-> shift_amount_out == nw_out[NW_SHA_LO +: SHA_W]
      && shift_ctrl_out == nw_out[NW_SHC_LO +: SHC_W])
      else $error("shift fields differ from word");
   AST_CS_HOLD: assert property ($changed(cs_bus_out)
      |-> $past(cs_rd_out, 3))
      else $error("cs bus changed without read");
   AST_PARAM: assert property ($changed(param_reg_out)
      |-> param_reg_out == {6'h00, cs_bus_out[MI_AB_W-1:0]})
      else $error("register 31 load wrong");
endmodule : nps_sequencer_asserts

// File: tb/testbench.sv
// Purpose: directed run of start, idle loop, interrupt and prefetch
// Assumes: zero-wait AHB-Lite slave, T-step of four clocks
// Notes:   chain: loop word, vector word, prefetch word twice, halt word
`define CHK(nm, ex, got) begin \
   samples_checked++; \
   if ((got) !== (ex)) begin \
      bad_count++; \
      $display("MISMATCH %s exp=%h got=%h", nm, ex, got); \
   end \
end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import nps_pkg::*;
   localparam logic [CSW-1:0]   M   = 18'h102;
   localparam logic [NSA_W-1:0] S_A = 10'h040;
   localparam logic [NSA_W-1:0] V_A = 10'h080;
   localparam logic [NSA_W-1:0] BR  = 10'h1ff;
   localparam logic [NSA_W-1:0] P_A = {4'h3, 6'h05};
   localparam logic [NSA_W-1:0] H_A = {4'h3, 6'h09};
   localparam logic [CSW-1:0]   I1  = {6'h05, 12'h9a5};
   localparam logic [CSW-1:0]   I3  = {6'h09, 12'h9a5};
   logic sys_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic irq = 1'b0, hready, hresp, ns_rd, cs_rd, ack, nw_valid, legal;
   logic allow, sh_gate;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
   logic [1:0] htrans = '0, tstep;
   logic [NSA_W-1:0] irq_addr = '0, ns_addr;
   logic [CSW-1:0] cs_addr, cs_data, param, cs_bus;
   logic [SHA_W-1:0] sha;
   logic [SHC_W-1:0] shc;
   nps_nw_t ns_data, nw, w_w, v_w, p_w, h_w;
   int bad_count = 0, samples_checked = 0, n;
   int ack_n = 0, sh_n = 0, both_n = 0, sha_n = 0;
   logic [CSW-1:0] csq [$];
   logic [NSA_W-1:0] nsq [$];
   nps_sequencer uut (.sys_clk_in(sys_clk), .reset_n_in(reset_n),
      .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
      .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
      .hresp_out(hresp), .ns_data_in(ns_data), .ns_addr_out(ns_addr),
      .ns_rd_out(ns_rd), .cs_data_in(cs_data), .cs_addr_out(cs_addr),
      .cs_rd_out(cs_rd), .irq_in(irq), .irq_addr_in(irq_addr),
      .irq_ack_out(ack), .nw_out(nw), .nw_valid_out(nw_valid),
      .tstep_out(tstep), .legal_entry_out(legal), .int_allow_out(allow),
      .shifter_gate_out(sh_gate), .shift_amount_out(sha),
      .shift_ctrl_out(shc), .param_reg_out(param), .cs_bus_out(cs_bus));
   nps_mem_model mem (.clk_in(sys_clk), .ns_addr_in(ns_addr),
      .ns_rd_in(ns_rd), .ns_data_out(ns_data), .cs_addr_in(cs_addr),
      .cs_rd_in(cs_rd), .cs_data_out(cs_data));
   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (cs_rd) csq.push_back(cs_addr);
      if (ns_rd) nsq.push_back(ns_addr);
      if (ack === 1'b1) ack_n++;
      if (sh_gate === 1'b1) sh_n++;
      if (ns_rd === 1'b1 && cs_rd === 1'b1) both_n++;
      if (sha === 6'h2a && shc === 2'h1) sha_n++;
   end
   function automatic nps_nw_t bit_at(input int b);
      return nps_nw_t'(1) << b;
   endfunction : bit_at
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict
   task automatic give_up();
      bad_count++;
      $display("MISMATCH wait exp=1 got=0");
      print_verdict();
   endtask : give_up
   // holds each phase until hready is sampled high at a rising edge
   task automatic bus_wait();
      int k;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (hready !== 1'b1 && k < 20);
      if (hready !== 1'b1) give_up();
   endtask : bus_wait
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge sys_clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      bus_wait();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      bus_wait();
      rd = hrdata;
      `CHK("response", 1'b0, hresp)
   endtask : bus
   task automatic chk_rd(input logic [7:0] a, input logic [31:0] ex,
                         input string nm);
      bus(1'b0, a, '0);
      `CHK(nm, ex, rd)
   endtask : chk_rd
   initial begin
      w_w = bit_at(NW_LEGAL) | bit_at(NW_ALLOW) | bit_at(CMD_NS_RD)
          | bit_at(9 + CMD_NS_RD) | bit_at(18 + CMD_NS_GATE);
      v_w = bit_at(NW_LEGAL) | bit_at(CMD_CS_RD_P1) | bit_at(9 + CMD_NPA_LD)
          | bit_at(9 + CMD_UPC_INC) | bit_at(18 + CMD_NS_RD)
          | bit_at(18 + CMD_SH_GATE) | bit_at(27 + CMD_NS_GATE)
          | bit_at(27 + CMD_PARAM_LD) | (nps_nw_t'(6'h2a) << NW_SHA_LO)
          | (nps_nw_t'(2'h1) << NW_SHC_LO);
      p_w = bit_at(NW_LEGAL) | bit_at(NW_ALLOW) | bit_at(CMD_NS_RD_BR)
          | bit_at(CMD_NPA_LD) | bit_at(9 + CMD_NS_RD) | bit_at(9 + CMD_CS_RD_P2)
          | bit_at(9 + CMD_UPC_INC) | bit_at(18 + CMD_NS_GATE)
          | bit_at(18 + CMD_PARAM_LD) | (nps_nw_t'(BR) << NW_BR_LO);
      h_w = bit_at(NW_LEGAL);
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk_rd(REG_STATUS, 32'h0, "status at reset");
      chk_rd(REG_UPC0, {14'h0, RST_UPC}, "counter at reset");
      bus(1'b1, 8'h3c, 32'hffff_ffff);
      chk_rd(8'h3c, 32'h0, "unmapped");
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, REG_UPC0 + 8'(4 * i), 32'h100 + i);
         chk_rd(REG_UPC0 + 8'(4 * i), 32'h100 + i, "counter");
      end
      mem.ns[S_A] = w_w;
      mem.ns[V_A] = v_w;
      mem.ns[P_A] = p_w;
      mem.ns[H_A] = h_w;
      mem.cs[M[9:0] + 10'h1] = I1;
      mem.cs[M[9:0] + 10'h3] = I3;
      mem.cs[M[9:0] + 10'h4] = I3;
      bus(1'b1, REG_SEL, 32'h32);
      bus(1'b1, REG_START, {22'h0, S_A});
      bus(1'b1, REG_CTRL, 32'h3);
      repeat (60) @(posedge sys_clk);
      `CHK("loop word", w_w, nw)
      `CHK("legal", 1'b1, legal)
      `CHK("allow", 1'b1, allow)
      `CHK("idle shift", 6'h00, sha)
      `CHK("held address", S_A, nsq[$])
      `CHK("repeats", 1'b1, nsq.size() > 4)
      irq_addr <= V_A;
      irq <= 1'b1;
      for (n = 0; n < 200 && ack_n == 0; n++) @(posedge sys_clk);
      irq <= 1'b0;
      if (ack_n == 0) give_up();
      n = 0;
      do begin
         bus(1'b0, REG_STATUS, '0);
         n++;
      end while (rd[1:0] !== 2'h0 && n < 60);
      if (rd[1:0] !== 2'h0) give_up();
      `CHK("halted", 1'b1, rd[14])
      `CHK("npa", H_A, rd[13:4])
      `CHK("last read", H_A, nsq[$])
      `CHK("acks", 1, ack_n)
      `CHK("vector fields", 1'b1, sha_n > 0)
      `CHK("cs reads", 3, csq.size())
      `CHK("cs plus one", M + 18'h1, csq[0])
      `CHK("cs plus two", M + 18'h3, csq[1])
      `CHK("cs plus two again", M + 18'h4, csq[2])
      `CHK("shared step", 2, both_n)
      `CHK("shifter gates", 1, sh_n)
      `CHK("register 31", {6'h00, 12'h9a5}, param)
      `CHK("cs bus", I3, cs_bus)
      chk_rd(REG_UPC0 + 8'h8, {14'h0, M + 18'h3}, "counter two");
      print_verdict();
   end
endmodule : testbench
bind nps_sequencer nps_sequencer_asserts u_chk (.sys_clk_in, .reset_n_in,
   .irq_addr_in, .ns_addr_out, .ns_rd_out, .cs_rd_out, .irq_ack_out,
   .nw_out, .nw_valid_out, .tstep_out, .legal_entry_out, .int_allow_out,
   .shifter_gate_out, .shift_amount_out, .shift_ctrl_out, .param_reg_out,
   .cs_bus_out);
